// ===== design/mpef_pkg.sv
/*
 Constants, register map, flag layout and carrier types for the meter pulse
 and event flag block. Assumes a single 100 MHz clock and a plain register port.
*/
// Functional notes
// - Line frequency reported in millihertz from samples
// - Net energy equals positive minus negative, scaled
// - Energy readings wrap around, keeping the low 32 bits, on each accumulator overflow
// - Polarity bit picks active-high or active-low pulse
// - Pulse lasts programmed frames, default 156
// - Pulse ends after width unless retriggered; here an overrun trigger also ends it at once
// - Quantity select picks energy or RMS source
// - Include bits pick contributing phases
// - Accumulate each DSP cycle, subtract threshold, pulse
// - Interrupt asserted when flag and mask set
// - Low supply sets supply-fail flag
// - Checksum change sets its flag
// - Any energy accumulator overflow sets flag
// - RMS bits 23:8 above high levels flag
// - RMS voltage not above low level flags
// - Missing zero crossing within timeout flags
// - Energy sign change between DSP cycles flags
// - Each completed DSP cycle sets ready flag
// - New trigger while busy sets overrun flag
// - Per-phase copies of five event flags
// - Per-phase overflow bits per energy accumulator
// - Flags sticky; only host write or reset clears
// - Holdoff counter blocks pulses, decrements, resets 5
// - DSP cycle triggered every programmed line cycles
package mpef_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_OPCFG  = 8'h00;  // Polarity in bit 0
    localparam logic [7:0] REG_PCFG   = 8'h04;  // Quantity [2:0], include [6:4]
    localparam logic [7:0] REG_PWIDTH = 8'h08;
    localparam logic [7:0] REG_THR    = 8'h0C;
    localparam logic [7:0] REG_HOLD   = 8'h10;
    localparam logic [7:0] REG_LINE_CYCLES_PER_DSP  = 8'h14;
    localparam logic [7:0] REG_CURHI  = 8'h18;
    localparam logic [7:0] REG_VOLHI  = 8'h1C;
    localparam logic [7:0] REG_VOLLO  = 8'h20;
    localparam logic [7:0] REG_ZXTO   = 8'h24;
    localparam logic [7:0] REG_ECOEF  = 8'h28;
    localparam logic [7:0] REG_FLAG   = 8'h2C;  // Write one to clear
    localparam logic [7:0] REG_MASK   = 8'h30;
    localparam logic [7:0] REG_FREQ   = 8'h34;
    localparam logic [7:0] REG_PFLAG  = 8'h38;  // Phase A, B, C at stride
    localparam logic [7:0] REG_EOVR   = 8'h44;  // Phase A, B, C at stride
    localparam logic [7:0] REG_NET    = 8'h50;  // Phase A, B, C at stride
    localparam logic [7:0] REG_STAT   = 8'h5C;
    localparam logic [7:0] PH_STRIDE  = 8'h04;
    // Global flag bits
    localparam int FLG_PWR = 0;
    localparam int FLG_CHK = 1;
    localparam int FLG_EOV = 2;
    localparam int FLG_CHI = 3;
    localparam int FLG_VHI = 4;
    localparam int FLG_VLO = 5;
    localparam int FLG_NZX = 6;
    localparam int FLG_DIR = 7;
    localparam int FLG_RDY = 8;
    localparam int FLG_OVR = 9;
    localparam int NFLG    = 10;
    // Phase flag bits
    localparam int PF_CHI = 0;
    localparam int PF_VHI = 1;
    localparam int PF_VLO = 2;
    localparam int PF_NZX = 3;
    localparam int PF_DIR = 4;
    // Quantity select codes
    localparam logic [2:0] QS_ARITH = 3'h0;
    localparam logic [2:0] QS_ABS   = 3'h1;
    localparam logic [2:0] QS_VRMS  = 3'h2;
    localparam logic [2:0] QS_IRMS  = 3'h3;
    localparam logic [2:0] QS_POS   = 3'h4;
    localparam logic [2:0] QS_NEG   = 3'h5;
    // Reset values
    localparam logic [15:0] RST_PWIDTH = 16'h009C;
    localparam logic [7:0]  RST_HOLD   = 8'h05;
    localparam logic [7:0]  RST_LINE_CYCLES_PER_DSP  = 8'h0A;
    // Sample period and frequency numerator: 3 phases, mHz
    localparam int SAMPLE_PERIOD_NS = 40000;
    localparam logic [31:0] FREQ_NUM = 32'(3 * 1000 * (1000000000 / SAMPLE_PERIOD_NS));

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mpef_bus_t;

    // Per-phase results of the metering datapath for one DSP cycle
    typedef struct packed {
        logic [31:0] vrms;
        logic [31:0] irms;
        logic [31:0] epos;  // Positive energy gathered this DSP cycle
        logic [31:0] eneg;  // Negative energy gathered this DSP cycle
    } mpef_meas_t;

    typedef enum logic [1:0] {
        FS_IDLE   = 2'b00,
        FS_PHASE  = 2'b01,
        FS_FINISH = 2'b10
    } mpef_fsm_t;
endpackage : mpef_pkg

// ===== design/mpef_top.sv
/*
 Meter pulse generator and sticky event flag unit with interrupt output.
 Assumes datapath inputs (frame tick, sample tick, zero crossings, phase
 results, checksum) are on mclk_in; the supply-low pin is asynchronous.
*/
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module mpef_top (
    input  wire logic                          mclk_in,
    input  wire logic                          rstn_in,
    input  wire mpef_pkg::mpef_bus_t           bus_in,
    output logic [31:0]                        rdata_out,
    input  wire logic                          adc_frame_in,
    input  wire logic                          sample_tick_in,
    input  wire logic [2:0]                    zx_in,
    input  wire mpef_pkg::mpef_meas_t [2:0]    meas_in,
    input  wire logic [15:0]                   config_checksum_in,
    input  wire logic                          supply_low_in,
    output logic                               pulse_out,
    output logic                               irq_out
);
    // All state of the block
    typedef struct packed {
        mpef_pkg::mpef_fsm_t     fsm;
        logic [1:0]              ph;        // Phase being processed
        logic                    sf_s1;     // Supply pin synchroniser
        logic                    sf_s2;

        // Host-programmed configuration
        logic                    pol;       // Pulse polarity bit
        logic [2:0]              qsel;
        logic [2:0]              incl;
        logic [15:0]             pwidth;
        logic [31:0]             thr;
        logic [7:0]              hold;
        logic [7:0]              line_cycles_per_dsp;
        logic [15:0]             curhi;
        logic [15:0]             volhi;
        logic [15:0]             vollo;
        logic [15:0]             zxto;
        logic [15:0]             ecoef;

        // Sticky event flags, mask and per-phase copies
        logic [9:0]              flag;
        logic [9:0]              mask;
        logic [2:0][4:0]         pflag;
        logic [2:0][1:0]         eovr;      // Bit 0 positive, bit 1 negative

        // Energy accumulators, one pair per phase
        logic [2:0][31:0]        epos;
        logic [2:0][31:0]        eneg;

        // Direction and zero-crossing tracking per phase
        logic [2:0]              dsign;     // Last energy sign, 1 negative
        logic [2:0]              dvld;
        logic [2:0][15:0]        zxcnt;     // Samples since last crossing
        logic [2:0][15:0]        nscnt;
        logic [2:0][15:0]        ns;        // Samples of last line cycle

        // Line frequency and line-cycle count
        logic [31:0]             freq;
        logic [7:0]              lcnt;

        // Pulse generator; signed so arithmetic energy may go negative
        logic signed [47:0]      pacc;
        logic [15:0]             pcnt;
        logic                    pact;

        // Checksum watch
        logic [15:0]             csum;
        logic                    cvld;

        // Registered outputs
        logic                    pulse;
        logic                    irq;
        logic [31:0]             rdata;
    } mpef_state_t;

    mpef_state_t        st_r;               // Registered state
    mpef_state_t        st_nxt;             // Next state
    logic signed [47:0] qty;                // Selected pulse quantity
    logic [32:0]        sum_p;              // Energy add with carry
    logic [32:0]        sum_n;
    logic [17:0]        ns_sum;
    logic [47:0]        prod;               // Net energy times coefficient
    logic               trig;               // DSP cycle trigger
    mpef_pkg::mpef_meas_t m;                // Phase under processing

    // Next-state logic: host access first so that hardware sets win
    always_comb begin
        st_nxt = st_r;
        qty    = '0;
        sum_p  = '0;
        sum_n  = '0;
        prod   = '0;
        m      = meas_in[st_r.ph];
        st_nxt.sf_s1 = supply_low_in;
        st_nxt.sf_s2 = st_r.sf_s1;
        st_nxt.rdata = '0;
        ns_sum = 18'(st_r.ns[0]) + 18'(st_r.ns[1]) + 18'(st_r.ns[2]);

        // Register reads, data valid in the next cycle only
        if (bus_in.rd) begin
            case (bus_in.addr)
                mpef_pkg::REG_OPCFG:  st_nxt.rdata = {31'h0, st_r.pol};
                mpef_pkg::REG_PCFG:   st_nxt.rdata = {25'h0, st_r.incl, 1'b0, st_r.qsel};
                mpef_pkg::REG_PWIDTH: st_nxt.rdata = {16'h0, st_r.pwidth};
                mpef_pkg::REG_THR:    st_nxt.rdata = st_r.thr;
                mpef_pkg::REG_HOLD:   st_nxt.rdata = {24'h0, st_r.hold};
                mpef_pkg::REG_LINE_CYCLES_PER_DSP:  st_nxt.rdata = {24'h0, st_r.line_cycles_per_dsp};
                mpef_pkg::REG_CURHI:  st_nxt.rdata = {16'h0, st_r.curhi};
                mpef_pkg::REG_VOLHI:  st_nxt.rdata = {16'h0, st_r.volhi};
                mpef_pkg::REG_VOLLO:  st_nxt.rdata = {16'h0, st_r.vollo};
                mpef_pkg::REG_ZXTO:   st_nxt.rdata = {16'h0, st_r.zxto};
                mpef_pkg::REG_ECOEF:  st_nxt.rdata = {16'h0, st_r.ecoef};
                mpef_pkg::REG_FLAG:   st_nxt.rdata = {22'h0, st_r.flag};
                mpef_pkg::REG_MASK:   st_nxt.rdata = {22'h0, st_r.mask};
                mpef_pkg::REG_FREQ:   st_nxt.rdata = st_r.freq;
                mpef_pkg::REG_STAT:   st_nxt.rdata = {22'h0, st_r.hold, st_r.fsm};
                default:              st_nxt.rdata = '0;   // Unmapped reads zero
            endcase
            for (int p = 0; p < 3; p++) begin
                if (bus_in.addr == mpef_pkg::REG_PFLAG + 8'(p * 4)) begin
                    st_nxt.rdata = {27'h0, st_r.pflag[p]};
                end
                if (bus_in.addr == mpef_pkg::REG_EOVR + 8'(p * 4)) begin
                    st_nxt.rdata = {30'h0, st_r.eovr[p]};
                end
                if (bus_in.addr == mpef_pkg::REG_NET + 8'(p * 4)) begin
                    prod = 48'(st_r.epos[p] - st_r.eneg[p]) * 48'(st_r.ecoef);
                    st_nxt.rdata = prod[31:0];
                end
            end
        end

        // Register writes; flag registers are write-one-to-clear
        if (bus_in.wr) begin
            case (bus_in.addr)
                mpef_pkg::REG_OPCFG:  st_nxt.pol = bus_in.wdata[0];
                mpef_pkg::REG_PCFG: begin
                    st_nxt.qsel = bus_in.wdata[2:0];
                    st_nxt.incl = bus_in.wdata[6:4];
                end
                mpef_pkg::REG_PWIDTH: st_nxt.pwidth = bus_in.wdata[15:0];
                mpef_pkg::REG_THR:    st_nxt.thr = bus_in.wdata;
                mpef_pkg::REG_HOLD:   st_nxt.hold = bus_in.wdata[7:0];
                mpef_pkg::REG_LINE_CYCLES_PER_DSP:  st_nxt.line_cycles_per_dsp = bus_in.wdata[7:0];
                mpef_pkg::REG_CURHI:  st_nxt.curhi = bus_in.wdata[15:0];
                mpef_pkg::REG_VOLHI:  st_nxt.volhi = bus_in.wdata[15:0];
                mpef_pkg::REG_VOLLO:  st_nxt.vollo = bus_in.wdata[15:0];
                mpef_pkg::REG_ZXTO:   st_nxt.zxto = bus_in.wdata[15:0];
                mpef_pkg::REG_ECOEF:  st_nxt.ecoef = bus_in.wdata[15:0];
                mpef_pkg::REG_FLAG:   st_nxt.flag = st_r.flag & ~bus_in.wdata[9:0];
                mpef_pkg::REG_MASK:   st_nxt.mask = bus_in.wdata[9:0];
                default: ;                                  // Other writes ignored
            endcase
            for (int p = 0; p < 3; p++) begin
                if (bus_in.addr == mpef_pkg::REG_PFLAG + 8'(p * 4)) begin
                    st_nxt.pflag[p] = st_r.pflag[p] & ~bus_in.wdata[4:0];
                end
                if (bus_in.addr == mpef_pkg::REG_EOVR + 8'(p * 4)) begin
                    st_nxt.eovr[p] = st_r.eovr[p] & ~bus_in.wdata[1:0];
                end
            end
        end

        // Level-sensitive supply fail: re-sets while the supply stays low
        if (st_r.sf_s2) begin
            st_nxt.flag[mpef_pkg::FLG_PWR] = 1'b1;
        end

        // Checksum watch; first cycle after reset only primes the copy
        st_nxt.csum = config_checksum_in;
        st_nxt.cvld = 1'b1;
        if (st_r.cvld && config_checksum_in != st_r.csum) begin
            st_nxt.flag[mpef_pkg::FLG_CHK] = 1'b1;
        end

        // Zero-crossing timing per phase
        for (int p = 0; p < 3; p++) begin
            if (zx_in[p]) begin
                // Keep the sample count of the line cycle just ended
                st_nxt.ns[p]    = st_r.nscnt[p];
                st_nxt.nscnt[p] = '0;
                st_nxt.zxcnt[p] = '0;
            end else if (sample_tick_in) begin
                if (st_r.nscnt[p] != 16'hFFFF) begin
                    st_nxt.nscnt[p] = st_r.nscnt[p] + 16'h0001;
                end
                // Counter stops at the timeout so one expiry flags once
                if (st_r.zxto != 16'h0000 && st_r.zxcnt[p] != st_r.zxto) begin
                    st_nxt.zxcnt[p] = st_r.zxcnt[p] + 16'h0001;
                    if (st_r.zxcnt[p] + 16'h0001 == st_r.zxto) begin
                        st_nxt.pflag[p][mpef_pkg::PF_NZX] = 1'b1;
                        st_nxt.flag[mpef_pkg::FLG_NZX]    = 1'b1;
                    end
                end
            end
        end

        // Pulse width timing in ADC frames
        if (st_r.pact && adc_frame_in) begin
            // Last frame ends the pulse; a width of zero acts as one frame
            if (st_r.pcnt <= 16'h0001) begin
                st_nxt.pact = 1'b0;
            end else begin
                st_nxt.pcnt = st_r.pcnt - 16'h0001;
            end
        end

        // Line cycles counted on phase A crossings
        trig = 1'b0;
        if (zx_in[0]) begin
            if (st_r.lcnt + 8'h01 >= st_r.line_cycles_per_dsp) begin
                st_nxt.lcnt = '0;
                trig = 1'b1;
            end else begin
                st_nxt.lcnt = st_r.lcnt + 8'h01;
            end
        end

        // DSP post-processing sequencer
        case (st_r.fsm)
            mpef_pkg::FS_IDLE: begin
                // Wait for the line-cycle counter to fire
                if (trig) begin
                    st_nxt.fsm = mpef_pkg::FS_PHASE;
                    st_nxt.ph  = 2'h0;
                end
            end
            mpef_pkg::FS_PHASE: begin
                // Energy accumulators, held off while settling
                if (st_r.hold == 8'h00) begin
                    sum_p = {1'b0, st_r.epos[st_r.ph]} + {1'b0, m.epos};
                    sum_n = {1'b0, st_r.eneg[st_r.ph]} + {1'b0, m.eneg};
                    st_nxt.epos[st_r.ph] = sum_p[31:0];
                    st_nxt.eneg[st_r.ph] = sum_n[31:0];
                    if (sum_p[32]) begin
                        st_nxt.eovr[st_r.ph][0] = 1'b1;
                        st_nxt.flag[mpef_pkg::FLG_EOV] = 1'b1;
                    end
                    if (sum_n[32]) begin
                        st_nxt.eovr[st_r.ph][1] = 1'b1;
                        st_nxt.flag[mpef_pkg::FLG_EOV] = 1'b1;
                    end
                end
                // Threshold checks on RMS bits 23:8
                if (m.irms[23:8] > st_r.curhi) begin
                    st_nxt.pflag[st_r.ph][mpef_pkg::PF_CHI] = 1'b1;
                    st_nxt.flag[mpef_pkg::FLG_CHI] = 1'b1;
                end
                if (m.vrms[23:8] > st_r.volhi) begin
                    st_nxt.pflag[st_r.ph][mpef_pkg::PF_VHI] = 1'b1;
                    st_nxt.flag[mpef_pkg::FLG_VHI] = 1'b1;
                end
                if (!(m.vrms[23:8] > st_r.vollo)) begin
                    st_nxt.pflag[st_r.ph][mpef_pkg::PF_VLO] = 1'b1;
                    st_nxt.flag[mpef_pkg::FLG_VLO] = 1'b1;
                end
                // Direction of net energy against the previous cycle
                st_nxt.dsign[st_r.ph] = m.eneg > m.epos;
                st_nxt.dvld[st_r.ph]  = 1'b1;
                if (st_r.dvld[st_r.ph] && st_r.dsign[st_r.ph] != (m.eneg > m.epos)) begin
                    st_nxt.pflag[st_r.ph][mpef_pkg::PF_DIR] = 1'b1;
                    st_nxt.flag[mpef_pkg::FLG_DIR] = 1'b1;
                end
                // Pulse quantity of this phase
                case (st_r.qsel)
                    mpef_pkg::QS_ARITH: qty = $signed({16'h0, m.epos}) - $signed({16'h0, m.eneg});
                    mpef_pkg::QS_ABS:   qty = $signed({16'h0, m.epos}) + $signed({16'h0, m.eneg});
                    mpef_pkg::QS_VRMS:  qty = $signed({16'h0, m.vrms});
                    mpef_pkg::QS_IRMS:  qty = $signed({16'h0, m.irms});
                    mpef_pkg::QS_POS:   qty = $signed({16'h0, m.epos});
                    mpef_pkg::QS_NEG:   qty = $signed({16'h0, m.eneg});
                    default:            qty = '0;
                endcase
                if (st_r.incl[st_r.ph] && st_r.hold == 8'h00) begin
                    st_nxt.pacc = st_r.pacc + qty;
                end
                // Step through phases A, B, C, one per clock
                if (st_r.ph == 2'h2) begin
                    st_nxt.fsm = mpef_pkg::FS_FINISH;
                end else begin
                    st_nxt.ph = st_r.ph + 2'h1;
                end
            end
            mpef_pkg::FS_FINISH: begin
                // Holdoff blocks pulses until it counts down to zero
                if (st_r.hold != 8'h00) begin
                    st_nxt.hold = st_r.hold - 8'h01;
                end else if (st_r.pacc > $signed({16'h0, st_r.thr})) begin
                    st_nxt.pacc = st_r.pacc - $signed({16'h0, st_r.thr});
                    st_nxt.pact = 1'b1;
                    st_nxt.pcnt = st_r.pwidth;
                end
                // Mean of the per-phase sample counts sets the frequency
                st_nxt.freq = (ns_sum == 18'h0) ? 32'h0
                            : mpef_pkg::FREQ_NUM / 32'(ns_sum);
                st_nxt.flag[mpef_pkg::FLG_RDY] = 1'b1;
                st_nxt.fsm = mpef_pkg::FS_IDLE;
            end
            default: st_nxt.fsm = mpef_pkg::FS_IDLE;
        endcase

        // A trigger during processing is an overrun; pulse is invalidated
        if (trig && st_r.fsm != mpef_pkg::FS_IDLE) begin
            st_nxt.flag[mpef_pkg::FLG_OVR] = 1'b1;
            st_nxt.pact = 1'b0;
        end

        // Outputs are built from the next state so each leaves a flip-flop
        st_nxt.pulse = st_nxt.pact ^ st_nxt.pol;
        st_nxt.irq   = |(st_nxt.flag & st_nxt.mask);
    end

    // State register; asynchronous reset loads the power-up values
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r        <= '0;
            st_r.fsm    <= mpef_pkg::FS_IDLE;
            st_r.pwidth <= mpef_pkg::RST_PWIDTH;
            st_r.hold   <= mpef_pkg::RST_HOLD;
            st_r.line_cycles_per_dsp  <= mpef_pkg::RST_LINE_CYCLES_PER_DSP;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out = st_r.rdata;
    assign pulse_out = st_r.pulse;
    assign irq_out   = st_r.irq;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    // Trigger and firing conditions of the sequencer
    sequence s_busy_trig;
        zx_in[0] && (st_r.lcnt + 8'h01 >= st_r.line_cycles_per_dsp) && st_r.fsm != mpef_pkg::FS_IDLE;
    endsequence
    sequence s_fire;
        st_r.fsm == mpef_pkg::FS_FINISH && st_r.hold == 8'h00
            && st_r.pacc > $signed({16'h0, st_r.thr});
    endsequence
    sequence s_no_trig;
        !(zx_in[0] && (st_r.lcnt + 8'h01 >= st_r.line_cycles_per_dsp));
    endsequence


    // Interrupt request, flag, holdoff and pulse checks
    AST_IRQ_SET: assert property (|(st_r.flag & st_r.mask) |-> irq_out)
        else $error("irq low with enabled flag");
    AST_IRQ_MASKED: assert property ((st_r.flag & st_r.mask) == 10'h0 |-> !irq_out)
        else $error("irq high with no enabled flag");
    AST_IRQ_HOLD: assert property (irq_out && !bus_in.wr |=> irq_out)
        else $error("irq dropped without host write");
    AST_STICKY: assert property (!(bus_in.wr && bus_in.addr == mpef_pkg::REG_FLAG)
        |=> (st_r.flag & $past(st_r.flag)) == $past(st_r.flag))
        else $error("flag cleared without host write");
    AST_RDY: assert property (st_r.fsm == mpef_pkg::FS_FINISH |=> st_r.flag[mpef_pkg::FLG_RDY])
        else $error("ready flag not set");
    AST_OVR: assert property (s_busy_trig |=> st_r.flag[mpef_pkg::FLG_OVR] && !st_r.pact)
        else $error("overrun not flagged");
    AST_FIRE: assert property (s_fire ##0 s_no_trig |=> st_r.pact
        && st_r.pacc == $past(st_r.pacc) - $signed({16'h0, $past(st_r.thr)}))
        else $error("threshold crossing mishandled");
    AST_HOLDOFF: assert property (st_r.fsm == mpef_pkg::FS_FINISH && st_r.hold != 8'h00
        |=> st_r.hold == $past(st_r.hold) - 8'h01 && st_r.pacc == $past(st_r.pacc))
        else $error("holdoff not honoured");
    AST_WIDTH: assert property (st_r.pact && !adc_frame_in && !zx_in[0] |=> st_r.pact)
        else $error("pulse ended between frames");
    AST_POL: assert property (pulse_out == (st_r.pact ^ st_r.pol))
        else $error("pulse level wrong for polarity");
    AST_SUPPLY_FAIL_FLAG: assert property (st_r.sf_s2 |=> st_r.flag[mpef_pkg::FLG_PWR])
        else $error("supply fail not flagged");
endmodule : mpef_top

// ===== sim/mpef_host.sv
/*
 Host model: masters the register port of the meter pulse and flag block.
 Assumes one rising-edge clock and a slave that never stalls.
*/
`timescale 1ns/1ps
module mpef_host (
    input  wire logic           mclk_in,
    output mpef_pkg::mpef_bus_t bus_out
);
    initial bus_out = '0;  // Idle port from time zero

    // One-cycle write; flag clears go through here as W1C
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus_out.wr <= 1'b0;
    endtask : wr

    // One-cycle read; data is taken by the bench one cycle later
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in);
        bus_out <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus_out.rd <= 1'b0;
    endtask : rd
endmodule : mpef_host

// ===== sim/meter_pulse_and_event_flags_tb.sv
/*
 Self-checking bench: reads are checked through a queue at the negedge.
 Assumes mpef_host as register master and a 100 MHz clock.
*/
`timescale 1ns/1ps
module meter_pulse_and_event_flags_tb;
    logic                       mclk_in = 1'b0;
    logic                       rstn_in = 1'b0;
    mpef_pkg::mpef_bus_t        bus;
    logic [31:0]                rdata;
    logic                       pulse;
    logic                       irq;
    logic [2:0]                 zx = 3'h0;
    logic [1:0]                 fc = 2'h0;
    logic                       frame = 1'b0;
    logic                       slow = 1'b0;
    logic [15:0]                cks = 16'h0012;  // LFSR seed
    logic                       rd_d = 1'b0;
    logic [31:0]                exp_q[$];
    int                         err_count = 0;
    int                         comparisons = 0;
    // Same stimulus on every phase: small VRMS, no current, positive energy
    mpef_pkg::mpef_meas_t [2:0] meas = {3{32'h0000_1000, 32'h0, 32'h0000_0064, 32'h0}};
    mpef_host i_host (.mclk_in(mclk_in), .bus_out(bus));
    mpef_top i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata),
        .adc_frame_in(frame), .sample_tick_in(frame), .zx_in(zx), .meas_in(meas),
        .config_checksum_in(cks), .supply_low_in(slow), .pulse_out(pulse), .irq_out(irq));
    initial forever #5 mclk_in = ~mclk_in;
    // Frame tick every fourth cycle keeps pulse widths short
    always @(posedge mclk_in) begin
        fc <= fc + 2'h1;
        frame <= (fc == 2'h0);
        rd_d <= bus.rd;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, seen, want);
        end
    endtask : check
    // Read data stands only in the cycle after the strobe
    always @(negedge mclk_in) if (rd_d === 1'b1) check(rdata, exp_q.pop_front());
    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_host.rd(a);
    endtask : rd_exp
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    // Phase A crossings two cycles apart; two of them force an overrun
    task automatic trig(input int n);
        repeat (n) begin
            @(posedge mclk_in) zx <= 3'h1;
            @(posedge mclk_in) zx <= 3'h0;
        end
        repeat (10) @(posedge mclk_in);
    endtask : trig
    task automatic end_sim;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge mclk_in);
        err_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        rstn_in <= 1'b1;
        rd_exp(mpef_pkg::REG_PWIDTH, 32'h0000_009C);
        rd_exp(mpef_pkg::REG_HOLD, 32'h0000_0005);
        rd_exp(8'hFC, 32'h0);
        i_host.wr(mpef_pkg::REG_LINE_CYCLES_PER_DSP, 32'h1);
        i_host.wr(mpef_pkg::REG_CURHI, 32'hFFFF);
        i_host.wr(mpef_pkg::REG_VOLHI, 32'hFFFF);
        i_host.wr(mpef_pkg::REG_HOLD, 32'h0);
        i_host.wr(mpef_pkg::REG_THR, 32'h0000_000A);
        i_host.wr(mpef_pkg::REG_PCFG, 32'h0000_0014);  // Positive energy, phase A only
        i_host.wr(mpef_pkg::REG_OPCFG, 32'h1);  // Active-low pulse
        i_host.wr(mpef_pkg::REG_PWIDTH, 32'h0000_0040);
        @(posedge mclk_in) #1 check(pulse, 1'b1);
        trig(1);
        #1 check(pulse, 1'b0);
        check(irq, 1'b0);
        rd_exp(mpef_pkg::REG_FLAG, 32'h0000_0100);
        i_host.wr(mpef_pkg::REG_MASK, 32'h0000_0100);
        repeat (2) @(posedge mclk_in);
        #1 check(irq, 1'b1);
        i_host.wr(mpef_pkg::REG_FLAG, 32'h0000_0100);
        repeat (2) @(posedge mclk_in);
        #1 check(irq, 1'b0);
        repeat (300) @(posedge mclk_in);
        #1 check(pulse, 1'b1);
        trig(2);
        rd_exp(mpef_pkg::REG_FLAG, 32'h0000_0300);
        @(posedge mclk_in) slow <= 1'b1;
        repeat (5) @(posedge mclk_in);
        slow <= 1'b0;
        repeat (4) @(posedge mclk_in);
        rd_exp(mpef_pkg::REG_FLAG, 32'h0000_0301);
        @(posedge mclk_in) cks <= lfsr(cks);
        repeat (3) @(posedge mclk_in);
        rd_exp(mpef_pkg::REG_FLAG, 32'h0000_0303);
        i_host.wr(mpef_pkg::REG_FLAG, 32'h0000_03FF);
        rd_exp(mpef_pkg::REG_FLAG, 32'h0);
        // Phase A gathered two DSP cycles of 0x64 each, scaled by 3
        i_host.wr(mpef_pkg::REG_ECOEF, 32'h3);
        rd_exp(mpef_pkg::REG_NET, 32'h0000_0258);
        // No crossings any more: every phase times out after four samples
        i_host.wr(mpef_pkg::REG_ZXTO, 32'h4);
        repeat (30) @(posedge mclk_in);
        rd_exp(mpef_pkg::REG_FLAG, 32'h0000_0040);
        rd_exp(mpef_pkg::REG_PFLAG + mpef_pkg::PH_STRIDE, 32'h0000_0008);
        repeat (3) @(posedge mclk_in);
        end_sim();
    end
endmodule : meter_pulse_and_event_flags_tb
